// ### shared/arss_pkg.sv
// Package: register map, codes, field layout and carrier types of the aux relay selector
package arss_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int N_RELAYS = 2;
	localparam int N_SLOTS  = 3;
	localparam int CODE_W   = 4;
	localparam int IDX_W    = 5;
	localparam int N_CODES  = 32;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CFG     = 8'h00;
	localparam logic [7:0] OFF_LIST0   = 8'h04;
	localparam logic [7:0] OFF_LIST1   = 8'h08;
	localparam logic [7:0] OFF_PROT    = 8'h0C;
	localparam logic [7:0] OFF_STAT    = 8'h10;
	localparam logic [7:0] OFF_IRQ_STS = 8'h14;
	localparam logic [7:0] OFF_IRQ_MSK = 8'h18;
	localparam logic [7:0] OFF_NET     = 8'h1C;

	// ------------------------------------------------------------
	// Field positions and masks
	// ------------------------------------------------------------
	localparam int CFG_STRIDE   = 8;
	localparam int STAT_LOC     = 2;
	localparam int STAT_NET     = 3;
	localparam int STAT_REP_LSB = 8;
	localparam int NET_RUN_BIT  = 0;
	localparam int IRQ_REFUSED  = 2;
	localparam int IRQ_W        = 3;
	localparam logic [31:0] CFG_MASK  = 32'h0000_0F0F;
	localparam logic [31:0] LIST_MASK = 32'h00FF_FFFF;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [31:0] CFG_RST  = 32'h0000_0000;
	localparam logic [31:0] LIST_RST = 32'h0000_0000;
	localparam logic [31:0] PROT_RST = 32'hFFFF_FFFF;
	localparam logic [2:0]  MSK_RST  = 3'h0;

	// ------------------------------------------------------------
	// Relay configuration codes
	// ------------------------------------------------------------
	localparam logic [3:0] CODE_OFF        = 4'h0;
	localparam logic [3:0] CODE_FAULT      = 4'h1;
	localparam logic [3:0] CODE_FAULT_NOT  = 4'h2;
	localparam logic [3:0] CODE_BYP        = 4'h3;
	localparam logic [3:0] CODE_BYP_NOT    = 4'h4;
	localparam logic [3:0] CODE_ENER       = 4'h5;
	localparam logic [3:0] CODE_ENER_NOT   = 4'h6;
	localparam logic [3:0] CODE_WARN       = 4'h7;
	localparam logic [3:0] CODE_WARN_NOT   = 4'h8;
	localparam logic [3:0] CODE_CUSTOM     = 4'h9;
	localparam logic [3:0] CODE_CUSTOM_NOT = 4'hA;

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic any_fault;
		logic any_warn;
		logic bypassed;
		logic energized;
	} arss_cond_t;

	typedef struct packed {
		logic             valid;
		logic             is_warn;
		logic             pad;
		logic [IDX_W-1:0] idx;
	} arss_slot_t;

	typedef arss_slot_t [N_SLOTS-1:0] arss_list_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} arss_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} arss_wb_rsp_t;

endpackage

// ### verilog/arss_relay_sel.sv
// Condition selector for one auxiliary status relay
`timescale 1ns/10ps
module arss_relay_sel
	import arss_pkg::*;
(
	input  wire logic [arss_pkg::CODE_W-1:0]  code_i,
	input  wire arss_pkg::arss_cond_t         cond_i,
	input  wire arss_pkg::arss_list_t         list_i,
	input  wire logic [arss_pkg::N_CODES-1:0] fault_i,
	input  wire logic [arss_pkg::N_CODES-1:0] warn_i,
	input  wire logic [arss_pkg::N_CODES-1:0] prot_en_i,
	output logic                              level_o,
	output arss_pkg::arss_slot_t              report_o
);

	logic [N_SLOTS-1:0] hit_f;
	logic [N_SLOTS-1:0] hit_w;
	logic               custom;

	// ------------------------------------------------------------
	// Custom list match and reported code
	// ------------------------------------------------------------
	// Warnings are scanned first so any fault hit overwrites them
	always_comb
	begin
		hit_f    = '0;
		hit_w    = '0;
		report_o = '0;
		for (int k = 0; k < N_SLOTS; k++)
		begin
			if (list_i[k].valid && list_i[k].is_warn)
				hit_w[k] = warn_i[list_i[k].idx];
			else if (list_i[k].valid)
				hit_f[k] = fault_i[list_i[k].idx] & prot_en_i[list_i[k].idx];  // [RQ7]
		end
		for (int k = N_SLOTS - 1; k >= 0; k--)
		begin
			if (hit_w[k])
				report_o = list_i[k];
		end
		for (int k = N_SLOTS - 1; k >= 0; k--)
		begin
			if (hit_f[k])
				report_o = list_i[k];  // [RQ6]
		end
		custom = (|hit_f) | (|hit_w);  // [RQ5]
	end

	// ------------------------------------------------------------
	// Code decode
	// ------------------------------------------------------------
	// Unused codes behave like no function: safer than a random relay
	always_comb
	begin
		unique case (code_i)
			CODE_OFF:        level_o = 1'b0;                  // [RQ1]
			CODE_FAULT:      level_o = cond_i.any_fault;      // [RQ1]
			CODE_FAULT_NOT:  level_o = ~cond_i.any_fault;     // [RQ1]
			CODE_BYP:        level_o = cond_i.bypassed;       // [RQ2]
			CODE_BYP_NOT:    level_o = ~cond_i.bypassed;      // [RQ2]
			CODE_ENER:       level_o = cond_i.energized;      // [RQ3]
			CODE_ENER_NOT:   level_o = ~cond_i.energized;     // [RQ3]
			CODE_WARN:       level_o = cond_i.any_warn;       // [RQ4]
			CODE_WARN_NOT:   level_o = ~cond_i.any_warn;      // [RQ4]
			CODE_CUSTOM:     level_o = custom;                // [RQ5]
			CODE_CUSTOM_NOT: level_o = ~custom;               // [RQ5]
			default:         level_o = 1'b0;
		endcase
	end

endmodule

// ### verilog/arss_top.sv
// Auxiliary status relay selector with Wishbone register file
`timescale 1ns/10ps

// Notes on behaviour
// (RQ1) Code 1 follows any fault, code 2 its inverse, code 0 never changes.
// (RQ2) Code 3 follows bypass contactors closed, code 4 its inverse.
// (RQ3) Code 5 follows motor energized in any ramp, run or stop phase; 6 inverts.
// (RQ4) Code 7 follows any warning present, code 8 its inverse.
// (RQ5) Codes 9 and 10 follow a list of up to three fault or warning codes.
// (RQ6) With several listed codes present, fault codes are reported before warnings.
// (RQ7) A listed fault whose protection is disabled never moves the relay.
// (RQ8) A controller reading contacts should debounce status changes for about 20 ms.
// (RQ9) Network commands are taken only while local terminal control is deselected.
// (RQ10) Terminal control needs start_run_command assigned to at least one input.
// (RQ11) Two relays, each with its own code, selected independently.
// (RQ12) Relay outputs are registered; a new code acts the next cycle.
module arss_top
	import arss_pkg::*;
(
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	input  wire logic                         ce_i,
	input  wire arss_pkg::arss_wb_req_t       wb_i,
	output arss_pkg::arss_wb_rsp_t            wb_o,
	input  wire arss_pkg::arss_cond_t         cond_i,
	input  wire logic [arss_pkg::N_CODES-1:0] fault_code_i,
	input  wire logic [arss_pkg::N_CODES-1:0] warn_code_i,
	input  wire logic                         local_ctrl_i,
	output logic [arss_pkg::N_RELAYS-1:0]     relay_o,
	output logic                              net_run_o,
	output logic                              irq_o
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [31:0]         cfg_q, cfg_d;
	logic [31:0]         list_q [N_RELAYS];
	logic [31:0]         list_d [N_RELAYS];
	logic [31:0]         prot_q, prot_d;
	logic [IRQ_W-1:0]    sts_q, sts_d;
	logic [IRQ_W-1:0]    msk_q, msk_d;
	logic                irq_q, irq_d;
	logic                ack_q, ack_d;
	logic [31:0]         rdat_q, rdat_d;
	logic                net_q, net_d;
	logic                loc_meta_q;
	logic                loc_q;
	logic [N_RELAYS-1:0] relay_q, relay_d;
	arss_slot_t          rep_q [N_RELAYS];
	arss_slot_t          rep_d [N_RELAYS];
	logic [N_RELAYS-1:0] sel_lvl;
	arss_slot_t          sel_rep [N_RELAYS];
	logic [IRQ_W-1:0]    evt;
	logic                wr_stb;
	logic [7:0]          wadr;

	assign wb_o.ack  = ack_q;
	assign wb_o.dat  = rdat_q;
	assign relay_o   = relay_q;
	assign net_run_o = net_q;
	assign irq_o     = irq_q;

	// ------------------------------------------------------------
	// Per relay selectors
	// ------------------------------------------------------------
	// Each relay decodes its own code byte and custom list
	generate
		for (genvar i = 0; i < N_RELAYS; i++)
		begin : g_relay
			arss_relay_sel u_sel (
				.code_i    (cfg_q[i*CFG_STRIDE +: CODE_W]),  // [RQ11]
				.cond_i    (cond_i),
				.list_i    (arss_list_t'(list_q[i][23:0])),
				.fault_i   (fault_code_i),
				.warn_i    (warn_code_i),
				.prot_en_i (prot_q),
				.level_o   (sel_lvl[i]),
				.report_o  (sel_rep[i])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Local control pin synchroniser
	// ------------------------------------------------------------
	// Terminal pin is asynchronous; only loc_q is read by logic
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			loc_meta_q <= 1'b0;
			loc_q      <= 1'b0;
		end
		else if (ce_i)
		begin
			loc_meta_q <= local_ctrl_i;
			loc_q      <= loc_meta_q;
		end
	end

	// ------------------------------------------------------------
	// Byte lane merge
	// ------------------------------------------------------------
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// Bus, registers, relays and interrupts: next state
	// ------------------------------------------------------------
	// Writes land at the edge where the master sees ack high
	always_comb
	begin
		cfg_d   = cfg_q;
		list_d  = list_q;
		prot_d  = prot_q;
		msk_d   = msk_q;
		net_d   = net_q;
		evt     = '0;
		wadr    = {wb_i.adr[7:2], 2'b00};
		ack_d   = wb_i.cyc & wb_i.stb & ~ack_q;
		wr_stb  = wb_i.cyc & wb_i.stb & wb_i.we & ack_q;
		rdat_d  = rdat_q;
		relay_d = sel_lvl;  // [RQ12]
		rep_d   = sel_rep;
		if (ack_d)
		begin
			unique case (wadr)
				OFF_CFG:     rdat_d = cfg_q;
				OFF_LIST0:   rdat_d = list_q[0];
				OFF_LIST1:   rdat_d = list_q[1];
				OFF_PROT:    rdat_d = prot_q;
				OFF_STAT:    rdat_d = {8'h00, rep_q[1], rep_q[0], 4'h0, net_q, loc_q, relay_q};
				OFF_IRQ_STS: rdat_d = {29'h0000_0000, sts_q};
				OFF_IRQ_MSK: rdat_d = {29'h0000_0000, msk_q};
				OFF_NET:     rdat_d = {31'h0000_0000, net_q};
				default:     rdat_d = 32'h0000_0000;
			endcase
		end
		if (wr_stb)
		begin
			unique case (wadr)
				OFF_CFG:     cfg_d = wmerge(cfg_q, wb_i.dat, wb_i.sel) & CFG_MASK;
				OFF_LIST0:   list_d[0] = wmerge(list_q[0], wb_i.dat, wb_i.sel) & LIST_MASK;
				OFF_LIST1:   list_d[1] = wmerge(list_q[1], wb_i.dat, wb_i.sel) & LIST_MASK;
				OFF_PROT:    prot_d = wmerge(prot_q, wb_i.dat, wb_i.sel);
				OFF_IRQ_MSK:
				begin
					if (wb_i.sel[0])
						msk_d = wb_i.dat[IRQ_W-1:0];
				end
				OFF_NET:
				begin
					if (loc_q)
						evt[IRQ_REFUSED] = 1'b1;  // [RQ9]
					else if (wb_i.sel[0])
						net_d = wb_i.dat[NET_RUN_BIT];  // [RQ9]
				end
				default:     ;
			endcase
		end
		// Local control takes the starter away from the network
		if (loc_q)
			net_d = 1'b0;  // [RQ9]
		evt[N_RELAYS-1:0] = relay_d ^ relay_q;
		// Set beats clear so an edge in the clear cycle is kept
		sts_d = sts_q;
		if (wr_stb && wadr == OFF_IRQ_STS && wb_i.sel[0])
			sts_d = sts_q & ~wb_i.dat[IRQ_W-1:0];
		sts_d = sts_d | evt;
		irq_d = |(sts_d & msk_d);
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Clock enable low freezes every flop including the bus answer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cfg_q   <= CFG_RST;
			list_q  <= '{default: LIST_RST};
			prot_q  <= PROT_RST;
			sts_q   <= '0;
			msk_q   <= MSK_RST;
			irq_q   <= 1'b0;
			ack_q   <= 1'b0;
			rdat_q  <= '0;
			net_q   <= 1'b0;
			relay_q <= '0;
			rep_q   <= '{default: '0};
		end
		else if (ce_i)
		begin
			cfg_q   <= cfg_d;
			list_q  <= list_d;
			prot_q  <= prot_d;
			sts_q   <= sts_d;
			msk_q   <= msk_d;
			irq_q   <= irq_d;
			ack_q   <= ack_d;
			rdat_q  <= rdat_d;
			net_q   <= net_d;
			relay_q <= relay_d;
			rep_q   <= rep_d;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic [3:0] code0;
	logic [3:0] code1;
	assign code0 = cfg_q[3:0];
	assign code1 = cfg_q[CFG_STRIDE +: CODE_W];

	property p_follow(logic [3:0] c, logic src);
		ce_i && code0 == c |=> relay_q[0] == $past(src);
	endproperty

	sequence s_net_write;
		ce_i && wr_stb && wadr == OFF_NET;
	endsequence

	sequence s_both_listed;
		ce_i && code0 == CODE_CUSTOM && list_q[0][7] && !list_q[0][6] && list_q[0][15]
			&& list_q[0][14] && fault_code_i[list_q[0][4:0]] && prot_q[list_q[0][4:0]]
			&& warn_code_i[list_q[0][12:8]];
	endsequence

	a_off_code_idle: assert property (ce_i && code0 == CODE_OFF |=> !relay_q[0])  // [RQ1]
		else $error("relay moved with code off");
	a_fault_inverse: assert property (p_follow(CODE_FAULT_NOT, !cond_i.any_fault))  // [RQ1]
		else $error("fault inverse not followed");
	a_bypass_follow: assert property (p_follow(CODE_BYP, cond_i.bypassed))  // [RQ2]
		else $error("bypass not followed");
	a_ener_follow: assert property (p_follow(CODE_ENER, cond_i.energized))  // [RQ3]
		else $error("energized not followed");
	a_warn_inverse: assert property (p_follow(CODE_WARN_NOT, !cond_i.any_warn))  // [RQ4]
		else $error("warning inverse not followed");
	a_custom_fault_first: assert property (s_both_listed |=> rep_q[0] == $past(list_q[0][7:0]))  // [RQ6]
		else $error("warning reported ahead of fault");
	a_custom_set: assert property (s_both_listed |=> relay_q[0])  // [RQ5]
		else $error("custom relay not set");
	// Any disabled fault in slot 0 must never become the reported code
	a_disabled_fault: assert property (ce_i && list_q[0][7:6] == 2'b10  // [RQ7]
		&& !prot_q[list_q[0][4:0]] |=> rep_q[0] != $past(list_q[0][7:0]))
		else $error("disabled fault was reported");
	a_net_refused: assert property (s_net_write ##0 loc_q |=> !net_q && sts_q[IRQ_REFUSED])  // [RQ9]
		else $error("network command taken under local control");
	a_relay_indep: assert property (ce_i && code1 == CODE_OFF |=> !relay_q[1])  // [RQ11]
		else $error("relay 1 moved with code off");
	a_code_change: assert property (ce_i && wr_stb && wadr == OFF_CFG && wb_i.sel[0]  // [RQ12]
		&& wb_i.dat[3:0] == CODE_BYP_NOT ##1 ce_i |=> relay_q[0] == $past(!cond_i.bypassed))
		else $error("new code not applied next cycle");

endmodule

// ### testbench/arss_plc_model.sv
// Controller model that debounces the two relay contacts before trusting them
`timescale 1ns/10ps
module arss_plc_model #(
	parameter int STABLE_CYC = 4
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [1:0] contact_i,
	output logic [1:0]      seen_o
);
	logic [1:0] last_q;
	int         cnt_q [2];

	// ------------------------------------------------------------
	// Debounce
	// ------------------------------------------------------------
	// A level counts only once it held STABLE_CYC + 2 samples; a shock bounce is ignored
	always @(posedge clk_i)
	begin
		for (int i = 0; i < 2; i++)
		begin
			last_q[i] <= contact_i[i];
			if (rst_i || contact_i[i] != last_q[i])
				cnt_q[i] <= 0;
			else if (cnt_q[i] < STABLE_CYC)
				cnt_q[i] <= cnt_q[i] + 1;
			else
				seen_o[i] <= last_q[i];
			if (rst_i)
				seen_o[i] <= 1'b0;
		end
	end
endmodule

// ### testbench/arss_top_tb_top.sv
// Self-checking bench for the aux relay selector
`timescale 1ns/10ps
module arss_top_tb_top;
	import arss_pkg::*;

	logic         clk_i        = 1'b0;
	logic         rst_i        = 1'b1;
	arss_wb_req_t wb_i         = '0;
	arss_wb_rsp_t wb_o;
	arss_cond_t   cond_i       = '0;
	logic [31:0]  fault_code_i = 32'h0;
	logic [31:0]  warn_code_i  = 32'h0;
	logic         local_ctrl_i = 1'b0;
	logic         ce           = 1'b1;
	logic [1:0]   relay_o;
	logic         net_run_o;
	logic         irq_o;
	logic [1:0]   seen;
	logic [31:0]  rd;
	logic [3:0]   pats [4]     = '{4'h0, 4'hA, 4'h5, 4'hF};
	int           fails        = 0;
	int           checks       = 0;
	int           cycles       = 0;

	always #4 clk_i = ~clk_i;

	// Clock enable driven so that one scenario can freeze the block
	arss_top arss_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_i(wb_i),
		.wb_o(wb_o), .cond_i(cond_i), .fault_code_i(fault_code_i),
		.warn_code_i(warn_code_i), .local_ctrl_i(local_ctrl_i), .relay_o(relay_o),
		.net_run_o(net_run_o), .irq_o(irq_o));

	// Stands for the 20 ms wait, shortened to keep the run brief
	arss_plc_model #(.STABLE_CYC(4)) arss_plc_model_inst (.clk_i(clk_i), .rst_i(rst_i),
		.contact_i(relay_o), .seen_o(seen));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic end_sim;
		if (fails == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic single cycle; request held until ack is sampled high
	task automatic bus(input logic w, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clk_i);
		wb_i <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: adr, dat: dat};
		do
			@(posedge clk_i);
		while (wb_o.ack !== 1'b1);
		rd = wb_o.dat;
		wb_i <= '0;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// Expected relay level with an empty custom list
	function automatic logic exp_rel(input logic [3:0] c, input logic [3:0] k);
		logic [3:0] v;
		v = {k[3], k[1], k[0], k[2]};
		if (c == 4'hA)
			return 1'b1;
		if (c == 4'h0 || c > 4'h8)
			return 1'b0;
		return v[3 - (c - 1) / 2] ^ !c[0];
	endfunction

	// ------------------------------------------------------------
	// Hang guard
	// ------------------------------------------------------------
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			fails++;
			end_sim();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		tick(1);
		check(relay_o, 32'h0);
		bus(1'b0, OFF_PROT, 32'h0);
		check(rd, PROT_RST);
		bus(1'b0, 8'h20, 32'h0);
		check(rd, 32'h0);
		bus(1'b1, OFF_CFG, 32'hFFFF_FFFF);
		bus(1'b0, OFF_CFG, 32'h0);
		check(rd, CFG_MASK);
		// Every code on relay 0, its mirror code on relay 1
		for (int c = 0; c < 16; c++)
		begin
			bus(1'b1, OFF_CFG, {20'h0, 4'(15 - c), 4'h0, 4'(c)});
			for (int p = 0; p < 4; p++)
			begin
				@(posedge clk_i);
				cond_i <= arss_cond_t'(pats[p]);
				tick(1);
				check(relay_o, {exp_rel(4'(15 - c), pats[p]), exp_rel(4'(c), pats[p])});
			end
		end
		bus(1'b0, OFF_IRQ_STS, 32'h0);
		check(rd, 32'h3);
		check(irq_o, 32'h0);
		// One-cycle latency and interrupt on a relay change
		bus(1'b1, OFF_CFG, {28'h0, CODE_BYP});
		@(posedge clk_i);
		cond_i <= '0;
		bus(1'b1, OFF_IRQ_STS, 32'h7);
		bus(1'b1, OFF_IRQ_MSK, 32'h1);
		@(posedge clk_i);
		cond_i.bypassed <= 1'b1;
		#1;
		check(relay_o, 32'h0);
		tick(1);
		check(relay_o, 32'h1);
		tick(1);
		check(irq_o, 32'h1);
		bus(1'b1, OFF_IRQ_STS, 32'h1);
		tick(1);
		check(irq_o, 32'h0);
		// Clock enable low freezes the relay although its condition drops
		@(posedge clk_i);
		ce <= 1'b0;
		cond_i.bypassed <= 1'b0;
		repeat (3) @(posedge clk_i);
		ce <= 1'b1;
		#1;
		check(relay_o, 32'h1);
		tick(1);
		check(relay_o, 32'h0);
		// Custom list: fault ahead of warning, disabled protection ignored
		bus(1'b1, OFF_LIST0, 32'h0000_C785);
		bus(1'b1, OFF_LIST1, 32'h0000_C785);
		bus(1'b1, OFF_CFG, 32'h0000_0A09);
		@(posedge clk_i);
		fault_code_i <= 32'h20;
		warn_code_i <= 32'h80;
		tick(1);
		check(relay_o, 32'h1);
		bus(1'b0, OFF_STAT, 32'h0);
		check({rd[14], rd[12:8]}, 32'h05);
		fault_code_i <= 32'h0;
		bus(1'b0, OFF_STAT, 32'h0);
		check({rd[14], rd[12:8]}, 32'h27);
		warn_code_i <= 32'h0;
		tick(1);
		check(relay_o, 32'h2);
		bus(1'b1, OFF_PROT, 32'hFFFF_FFDF);
		fault_code_i <= 32'h20;
		tick(2);
		check(relay_o, 32'h2);
		tick(6);
		check(seen, relay_o);
		// Network command only without local control
		bus(1'b1, OFF_NET, 32'h1);
		tick(2);
		check(net_run_o, 32'h1);
		// Terminal control selected, network run command refused and flagged in IRQ status
		@(posedge clk_i);
		local_ctrl_i <= 1'b1;
		tick(5);
		check(net_run_o, 32'h0);
		bus(1'b1, OFF_NET, 32'h1);
		tick(2);
		check(net_run_o, 32'h0);
		bus(1'b0, OFF_IRQ_STS, 32'h0);
		check(rd[2], 32'h1);
		end_sim();
	end
endmodule
